// file: logic/ccoa_pkg.sv
/*
 Constants for the compare/capture channel output-action block.
 Assumes a 32-bit Avalon-MM register bus and one core clock.
*/
package ccoa_pkg;
   // ===========================================
   // Register map
   localparam logic [3:0] CCOA_CTRL_OFFSET = 4'h0;
   localparam logic [3:0] CCOA_STAT_OFFSET = 4'h4;
   // ===========================================
   // Control field positions
   localparam int CCOA_SEL_LSB = 16;
   localparam int CCOA_UF_LSB = 12;
   localparam int CCOA_OF_LSB = 10;
   localparam int CCOA_MT_LSB = 8;
   localparam logic [31:0] CCOA_CTRL_WMASK = 32'h000F_3F00;
   localparam logic [31:0] CCOA_CTRL_RESET = 32'h0000_0000;
   localparam logic [3:0] CCOA_SEL_RESET = 4'h0;
   localparam logic CCOA_OUT_RESET = 1'b0;
   localparam int CCOA_NUM_EVCH = 12;
   // ===========================================
   // Output actions
   typedef enum logic [1:0]
   {
      CCOA_ACT_NONE = 2'h0,
      CCOA_ACT_TOGGLE = 2'h1,
      CCOA_ACT_CLEAR = 2'h2,
      CCOA_ACT_SET = 2'h3
   } ccoa_action_t;
endpackage : ccoa_pkg

// file: logic/ccoa_action_apply.sv
/*
 Applies one output action to a level when its event fires.
 Assumes event and action are on the core clock domain.
*/
module ccoa_action_apply
(
   input wire logic i_event,
   input wire logic [1:0] i_action,
   input wire logic i_level,
   output logic o_level
);
   always_comb
   begin
      o_level = i_level;
      if (i_event)
      begin
         case (ccoa_pkg::ccoa_action_t'(i_action))
            ccoa_pkg::CCOA_ACT_NONE: o_level = i_level;
            ccoa_pkg::CCOA_ACT_TOGGLE: o_level = ~i_level;
            ccoa_pkg::CCOA_ACT_CLEAR: o_level = 1'b0;
            ccoa_pkg::CCOA_ACT_SET: o_level = 1'b1;
            default: o_level = i_level;
         endcase
      end
   end
endmodule : ccoa_action_apply

// file: logic/ccoa_channel.sv
/*
 Compare/capture channel control register, event input select and output
 actions on underflow, overflow and compare match.
 Assumes event pulses from the counter core on i_core_clk, event channels
 from other on-chip logic on the same clock, and an Avalon-MM master.
*/
// How it works
// RULE1: 4-bit event input select at bits 19:16, resets to zero.
// RULE2: Select value n of 7..11 routes event channel n to the input.
// RULE3: Underflow action bits 13:12: none, toggle, clear, set.
// RULE4: Overflow action bits 11:10: none, toggle, clear, set.
// RULE5: Match action bits 9:8: none, toggle, clear, set.
// RULE6: All three action fields reset to zero and are read/write.
// RULE7: Software writes zeros to bits 15:14 and 7:5.
// RULE8: Underflow action applies only on underflow; the output changes the cycle after the event.
// RULE9: Simultaneous events apply underflow, then overflow, then match.
module ccoa_channel
(
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic [3:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic [11:0] i_event_channels,
   input wire logic i_underflow,
   input wire logic i_overflow,
   input wire logic i_match,
   output logic o_channel_input,
   output logic o_channel_output
);
   // ===========================================
   // State
   typedef struct packed
   {
      logic [3:0] event_input_select;
      logic [1:0] underflow_output_action;
      logic [1:0] overflow_output_action;
      logic [1:0] match_output_action;
      logic out_level;
      logic chan_in;
      logic ack;
      logic [31:0] rdata;
   } ccoa_state_t;

   ccoa_state_t state_reg;
   ccoa_state_t state_next;
   logic lvl_uf;
   logic lvl_of;
   logic lvl_mt;
   logic [31:0] ctrl_view;
   logic [31:0] wr_merged;

   function automatic logic [31:0] ccoa_be_mask(input logic [3:0] be);
      ccoa_be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction : ccoa_be_mask

   // ===========================================
   // Output actions, fixed order
   ccoa_action_apply u_uf
   (
      .i_event(i_underflow), // RULE8
      .i_action(state_reg.underflow_output_action), // RULE3
      .i_level(state_reg.out_level),
      .o_level(lvl_uf)
   );
   ccoa_action_apply u_of
   (
      .i_event(i_overflow),
      .i_action(state_reg.overflow_output_action), // RULE4
      .i_level(lvl_uf), // RULE9
      .o_level(lvl_of)
   );
   ccoa_action_apply u_mt
   (
      .i_event(i_match),
      .i_action(state_reg.match_output_action), // RULE5
      .i_level(lvl_of), // RULE9
      .o_level(lvl_mt)
   );

   // ===========================================
   // Registers and bus
   always_comb
   begin
      ctrl_view = '0;
      ctrl_view[ccoa_pkg::CCOA_SEL_LSB +: 4] = state_reg.event_input_select;
      ctrl_view[ccoa_pkg::CCOA_UF_LSB +: 2] = state_reg.underflow_output_action;
      ctrl_view[ccoa_pkg::CCOA_OF_LSB +: 2] = state_reg.overflow_output_action;
      ctrl_view[ccoa_pkg::CCOA_MT_LSB +: 2] = state_reg.match_output_action;
      wr_merged = (ctrl_view & ~ccoa_be_mask(i_avs_byteenable))
         | (i_avs_writedata & ccoa_be_mask(i_avs_byteenable));
      wr_merged = wr_merged & ccoa_pkg::CCOA_CTRL_WMASK; // RULE7

      state_next = state_reg;
      state_next.out_level = lvl_mt; // RULE8
      state_next.ack = 1'b0;
      if (state_reg.event_input_select < 4'(ccoa_pkg::CCOA_NUM_EVCH))
      begin
         state_next.chan_in = i_event_channels[state_reg.event_input_select]; // RULE2
      end
      else
      begin
         state_next.chan_in = 1'b0;
      end
      if ((i_avs_read || i_avs_write) && !state_reg.ack)
      begin
         state_next.ack = 1'b1;
         state_next.rdata = '0;
         if (i_avs_write && i_avs_address == ccoa_pkg::CCOA_CTRL_OFFSET)
         begin
            state_next.event_input_select = wr_merged[ccoa_pkg::CCOA_SEL_LSB +: 4]; // RULE1
            state_next.underflow_output_action = wr_merged[ccoa_pkg::CCOA_UF_LSB +: 2]; // RULE6
            state_next.overflow_output_action = wr_merged[ccoa_pkg::CCOA_OF_LSB +: 2]; // RULE6
            state_next.match_output_action = wr_merged[ccoa_pkg::CCOA_MT_LSB +: 2]; // RULE6
         end
         if (i_avs_read)
         begin
            case (i_avs_address)
               ccoa_pkg::CCOA_CTRL_OFFSET: state_next.rdata = ctrl_view;
               ccoa_pkg::CCOA_STAT_OFFSET: state_next.rdata = {30'h0000_0000,
                  state_reg.chan_in, state_reg.out_level};
               default: state_next.rdata = '0;
            endcase
         end
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         state_reg <= '0; // RULE1
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !state_reg.ack;
   assign o_avs_readdata = state_reg.rdata;
   assign o_channel_output = state_reg.out_level;
   assign o_channel_input = state_reg.chan_in;
endmodule : ccoa_channel

// file: tb/ccoa_channel_asserts.sv
/* Port checker for ccoa_channel. Assumes full-word control writes. */
module ccoa_channel_asserts
(
   input logic i_core_clk, i_sys_rst, i_avs_read, i_avs_write, o_avs_waitrequest,
   input logic i_underflow, i_overflow, i_match, o_channel_input, o_channel_output,
   input logic [3:0] i_avs_address,
   input logic [11:0] i_event_channels,
   input logic [31:0] i_avs_writedata, o_avs_readdata
);
   logic [31:0] c_reg;
   wire ok = !o_avs_waitrequest;
   wire rd = i_avs_read && ok;
   wire u = i_underflow, v = i_overflow, m = i_match;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);
   always_ff @(posedge i_core_clk)
      if (i_sys_rst || i_avs_write && !ok && i_avs_address == 4'h0)
         c_reg <= i_sys_rst ? 32'h0 : i_avs_writedata;
   ack_next_a: assert property (i_avs_read && !ok |=> ok) else $error("ack");
   gap_zero_a: assert property (rd && i_avs_address[3] |-> o_avs_readdata == 0) else $error("gap");
   ctl_read_a: assert property (rd && i_avs_address == 4'h0 |-> o_avs_readdata == c_reg) else $error("rd");
   hold_out_a: assert property (!(u || v || m) |=> $stable(o_channel_output)) else $error("hold");
   uf_flip_a: assert property (u && !v && !m && c_reg[13:12] == 2'h1 |=> $changed(o_channel_output)) else $error("uf");
   of_low_a: assert property (v && !m && c_reg[11:10] == 2'h2 |=> !o_channel_output) else $error("of");
   mt_high_a: assert property (m && c_reg[9:8] == 2'h3 |=> o_channel_output) else $error("mt");
   sel_route_a: assert property (c_reg[19:16] inside {[4'h7:4'hB]} |=>
      o_channel_input == $past(i_event_channels[c_reg[19:16]])) else $error("sel");
endmodule : ccoa_channel_asserts
bind ccoa_channel ccoa_channel_asserts u_chk (.*);

// file: tb/ccoa_partner.sv
/* Counter core stand-in. Assumes bench random bits, zero when idle. */
module ccoa_partner
(
   input logic i_core_clk,
   input logic i_sys_rst,
   input logic [14:0] i_rnd,
   output logic [14:0] o_events
);
   always_ff @(posedge i_core_clk)
      o_events <= i_sys_rst ? 15'h0 : i_rnd;
endmodule : ccoa_partner

// file: tb/tb.sv
/* Bench for ccoa_channel. Assumes ccoa_partner as the counter core. */
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 0, rst = 1, rd = 0, wr = 0, en = 0, eo = 0, chin = 0, cout, cin, wt;
   logic [3:0] adr = 4'h0;
   logic [14:0] ev;
   logic [31:0] wd = 32'h0, ctl = 32'h0, lf = 32'h47a8, rdat, q[$];
   int err_count = 0, total_checks = 0, cyc = 0;
   always #12.5 clk = ~clk;
   ccoa_partner u_far(.i_core_clk(clk), .i_sys_rst(rst), .i_rnd(en ? lf[14:0] : 15'h0), .o_events(ev));
   ccoa_channel u_dut(.i_core_clk(clk), .i_sys_rst(rst), .i_avs_address(adr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF), .o_avs_readdata(rdat),
      .o_avs_waitrequest(wt), .i_event_channels(ev[11:0]), .i_underflow(ev[12]), .i_overflow(ev[13]),
      .i_match(ev[14]), .o_channel_input(cin), .o_channel_output(cout));
   function automatic logic act(logic [1:0] a, logic l);
      return a == 2'h1 ? !l : a[1] ? a[0] : l;
   endfunction : act
   task automatic chk(logic [31:0] g, e);
      total_checks++;
      err_count += 32'(g !== e);
      if (g !== e)
         $display("ERROR %0t got %h want %h", $time, g, e);
   endtask : chk
   task automatic close_out();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : close_out
   task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
      @(posedge clk);
      {rd, wr, adr, wd} <= {!w, w, a, d};
      if (w)
         ctl = d;
      else
         q.push_back(d);
      do @(posedge clk); while (wt);
      {rd, wr} <= 2'h0;
   endtask : bus
   always @(posedge clk)
   begin
      lf <= {lf[30:0], ^(lf & 32'h8020_0003)};
      cyc <= cyc + 1;
      chin <= !rst && ctl[19:16] < 4'hC && ev[ctl[19:16]];
      eo <= !rst && act(ev[14] ? ctl[9:8] : 2'h0,
         act(ev[13] ? ctl[11:10] : 2'h0, act(ev[12] ? ctl[13:12] : 2'h0, eo)));
      if (cyc == 5000)
      begin
         err_count++;
         close_out();
      end
   end
   always @(negedge clk)
      if (!rst)
      begin
         chk(32'(cout), 32'(eo));
         chk(32'(cin), 32'(chin));
         if (rd && !wt)
            chk(rdat, q.pop_front());
      end
   initial
   begin
      repeat (2) @(posedge clk);
      rst <= 0;
      bus(0, 4'h0, 32'h0);
      bus(0, 4'hC, 32'h0);
      $display("reset test done");
      for (int i = 0; i < 64; i++)
      begin
         bus(1, 4'h0, {12'h0, 4'(7 + i % 5), 2'h0, 6'(i), 8'h0});
         bus(0, 4'h0, ctl);
         en <= 1;
         repeat (12) @(posedge clk);
         en <= 0;
         repeat (2) @(posedge clk);
         bus(0, 4'h4, {31'h0, eo});
      end
      $display("action test done");
      close_out();
   end
endmodule : tb
